// ==== src/rf_tx_pkg.sv ====
// Package: register map, field positions and types of the RF transmit status and coding block
package rf_tx_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_STATUS_CTRL = 4'h0;  // rf_status_and_control
    localparam logic [3:0] ADDR_ZERO_HIGH   = 4'h1;  // fsk_zero_div_high (page 0)
    localparam logic [3:0] ADDR_ZERO_LOW    = 4'h2;  // fsk_zero_div_low_and_coding (page 0)
    localparam logic [3:0] ADDR_PAGE        = 4'h3;  // register_page_select
    localparam logic [3:0] ADDR_IRQ_STATUS  = 4'h4;  // sticky event status, write one to clear
    localparam logic [3:0] ADDR_IRQ_MASK    = 4'h5;  // event mask, one passes the event

    // ------------------------------------------------------------------
    // Field positions of rf_status_and_control
    // ------------------------------------------------------------------
    localparam int BIT_DONE   = 7;
    localparam int BIT_ERROR  = 6;
    localparam int BIT_LOWV   = 5;
    localparam int BIT_ACK    = 4;
    localparam int BIT_IRQEN  = 3;
    localparam int BIT_LVDEN  = 2;
    localparam int BIT_READY  = 1;
    localparam int BIT_RESET  = 0;

    // Field positions of fsk_zero_div_low_and_coding
    localparam int BIT_POL    = 2;
    localparam int FRAC_W     = 13;
    localparam int FRAC_LO_W  = 5;

    // ------------------------------------------------------------------
    // Constants and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  BYTE_ZERO    = 8'h00;
    localparam logic [12:0] FRAC_RESET   = 13'h0000;
    localparam logic [4:0]  RATIO_BASE   = 5'h0C;  // Integer part 12
    localparam logic [4:0]  RATIO_CF_ADD = 5'h04;  // Plus 4 with carrier_band_select
    localparam int          FRAC_DEN     = 8192;
    localparam real         FRAC_STEP_KHZ = 3.17;

    // Encoding and source selection
    typedef enum logic [1:0] {
        CODE_MANCHESTER = 2'b00,
        CODE_BIPHASE    = 2'b01,
        CODE_NRZ        = 2'b10,
        CODE_MCU_DIRECT = 2'b11
    } coding_type;

    // Interrupt event bits in the status and mask registers
    localparam int EV_DONE  = 0;
    localparam int EV_ERROR = 1;
    localparam int EV_LOWV  = 2;
    localparam int EV_W     = 3;

    // Coding configuration handed to the modulator
    typedef struct packed {
        logic [12:0] fsk_zero_fraction;
        logic        data_polarity;
        coding_type  coding;
        logic [4:0]  ratio_integer;
    } coding_cfg_type;

    // Events from the transmit engine and analog side
    typedef struct packed {
        logic tx_done;      // Buffer-mode frame sequence finished, send request cleared
        logic tx_error;     // Error detected in a transmission
        logic lowvolt_trip; // Supply fell below the falling threshold
        logic pll_locked;   // XCO, VCO and PLL started and locked
    } radio_event_type;

endpackage : rf_tx_pkg

// ==== src/rf_tx_status_and_encoding_ctrl.sv ====
// Status, interrupt and FSK zero-divider / encoding control registers of the RF transmitter
//
// Contract
// - Done flag bit 7 read-only, set on clean buffer-mode finish, writes ignored.
// - All three flags clear on acknowledge write, reset-bit write, or module reset.
// - Error flag bit 6 read-only, sticky after any transmission error.
// - Low-voltage flag bit 5 sets on trip while enable on, sticky.
// - Writing one to acknowledge bit 4 clears all flags; zero does nothing.
// - Interrupt enable bit 3 gates flags onto request; module reset clears it.
// - Bit 2 enables low-voltage detector and routes trips; module reset clears.
// - Ready bit 1 reads one only when oscillator and PLL locked.
// - Writing one to bit 0 resets the radio unit; reads zero.
// - Divider registers reachable only while page select is zero.
// - Fraction bits 12:5 in high register, bits 4:0 in low register 7:3.
// - Data zero ratio is 12 plus 4 times carrier select plus fraction/8192.
// - Fraction cleared by module reset; one step is nominally 3.17 kHz.
// - Polarity bit 2 inverts NRZ and direct data, picks coding variant.
// - Coding 00 Manchester, 01 Bi-Phase, 10 NRZ, 11 direct data bit.
// - Coding field returns to Manchester on module reset.
// - With frame delay zero, done sets after last frame of message.
//
// Local design decisions: the address-and-strobe port and the register addresses.
module rf_tx_status_and_encoding_ctrl
    import rf_tx_pkg::*;
(
    input  wire logic            mclk,
    input  wire logic            rst,
    input  wire logic [3:0]      addr,
    input  wire logic [7:0]      wdata,
    input  wire logic            wr,
    input  wire logic            rd,
    output logic      [7:0]      rdata,
    input  wire radio_event_type radio_event,
    input  wire logic            carrier_band_select,
    input  wire logic            frame_irq_delay,
    input  wire logic            tx_busy,
    input  wire logic            mcu_data_bit,
    output coding_cfg_type       coding_cfg,
    output logic                 radio_data_out,
    output logic                 radio_unit_reset,
    output logic                 rf_lowvolt_enable,
    output logic                 irq
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic              tx_done_flag;
    logic              tx_error_flag;
    logic              rf_lowvolt_flag;
    logic              rf_irq_enable;
    logic              ready_to_transmit;
    logic              register_page_select;
    logic [FRAC_W-1:0] fsk_zero_fraction;
    logic              data_polarity;
    coding_type        coding;
    logic [EV_W-1:0]   irq_status;
    logic [EV_W-1:0]   irq_mask;
    logic [EV_W-1:0]   events;
    logic              wr_ctrl;
    logic              flag_clear;
    logic              page0;
    logic              unit_rst;
    logic              buffer_mode;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    // Divider registers disappear while page one is selected
    assign page0      = ~register_page_select;
    assign wr_ctrl    = wr && (addr == ADDR_STATUS_CTRL);
    // Acknowledge and reset-bit writes both sweep the flags
    assign flag_clear = wr_ctrl && (wdata[BIT_ACK] || wdata[BIT_RESET]);
    // Module reset is the one-cycle self-clearing pulse only; the async reset is handled separately
    assign unit_rst   = radio_unit_reset;
    // Done only means something while data comes from the buffer
    assign buffer_mode = (coding != CODE_MCU_DIRECT);

    // Self-clearing radio reset pulse; an MCU reset only clears the pulse
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            radio_unit_reset <= 1'b0;
        end else begin
            radio_unit_reset <= wr_ctrl && wdata[BIT_RESET];
        end
    end

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    // Done only counts outside busy transmit; a set beats a same-cycle clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_done_flag <= 1'b0;
        end else if (unit_rst) begin
            tx_done_flag <= 1'b0;
        end else if (radio_event.tx_done && !tx_busy && buffer_mode) begin
            tx_done_flag <= 1'b1;
        end else if (flag_clear || tx_busy || !buffer_mode) begin
            tx_done_flag <= 1'b0;
        end
    end

    // Error flag is sticky across transmissions until acknowledged
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_error_flag <= 1'b0;
        end else if (unit_rst) begin
            tx_error_flag <= 1'b0;
        end else if (radio_event.tx_error) begin
            tx_error_flag <= 1'b1;
        end else if (flag_clear) begin
            tx_error_flag <= 1'b0;
        end
    end

    // Trips only count while the detector is enabled
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rf_lowvolt_flag <= 1'b0;
        end else if (unit_rst) begin
            rf_lowvolt_flag <= 1'b0;
        end else if (radio_event.lowvolt_trip && rf_lowvolt_enable) begin
            rf_lowvolt_flag <= 1'b1;
        end else if (flag_clear) begin
            rf_lowvolt_flag <= 1'b0;
        end
    end

    // Ready follows lock; module reset forces it low for a cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ready_to_transmit <= 1'b0;
        end else if (unit_rst) begin
            ready_to_transmit <= 1'b0;
        end else begin
            ready_to_transmit <= radio_event.pll_locked;
        end
    end

    // ------------------------------------------------------------------
    // Control bits
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rf_irq_enable     <= 1'b0;
            rf_lowvolt_enable <= 1'b0;
        end else if (unit_rst) begin
            rf_irq_enable     <= 1'b0;
            rf_lowvolt_enable <= 1'b0;
        end else if (wr_ctrl && !wdata[BIT_RESET]) begin
            rf_irq_enable     <= wdata[BIT_IRQEN];
            rf_lowvolt_enable <= wdata[BIT_LVDEN];
        end
    end

    // Page select lives outside the radio reset so software keeps its view
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            register_page_select <= 1'b0;
        end else if (wr && addr == ADDR_PAGE) begin
            register_page_select <= wdata[0];
        end
    end

    // ------------------------------------------------------------------
    // Divider fraction and coding
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fsk_zero_fraction <= FRAC_RESET;
            data_polarity     <= 1'b0;
            coding            <= CODE_MANCHESTER;
        end else if (unit_rst) begin
            fsk_zero_fraction <= FRAC_RESET;
            data_polarity     <= 1'b0;
            coding            <= CODE_MANCHESTER;
        end else if (wr && page0 && addr == ADDR_ZERO_HIGH) begin
            fsk_zero_fraction[FRAC_W-1:FRAC_LO_W] <= wdata;
        end else if (wr && page0 && addr == ADDR_ZERO_LOW) begin
            fsk_zero_fraction[FRAC_LO_W-1:0] <= wdata[7:3];
            data_polarity                    <= wdata[BIT_POL];
            coding                           <= coding_type'(wdata[1:0]);
        end
    end

    // Ratio integer; the fraction over FRAC_DEN, one step about FRAC_STEP_KHZ
    always_comb begin
        coding_cfg.fsk_zero_fraction = fsk_zero_fraction;
        coding_cfg.data_polarity     = data_polarity;
        coding_cfg.coding            = coding;
        coding_cfg.ratio_integer     = carrier_band_select ?
                                       RATIO_BASE + RATIO_CF_ADD : RATIO_BASE;
    end

    // Direct mode drives the software bit, polarity inverts it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            radio_data_out <= 1'b0;
        end else if (coding == CODE_MCU_DIRECT) begin
            radio_data_out <= mcu_data_bit ^ data_polarity;
        end else begin
            radio_data_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt: sticky status, mask, level output
    // ------------------------------------------------------------------
    assign events = {rf_lowvolt_flag, tx_error_flag, tx_done_flag};

    // Any flag that is high sets its sticky status bit; set wins over write-one clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_status <= '0;
        end else if (unit_rst) begin
            irq_status <= '0;
        end else begin
            for (int i = 0; i < EV_W; i++) begin
                if (events[i]) begin
                    irq_status[i] <= 1'b1;
                end else if (wr && addr == ADDR_IRQ_STATUS && wdata[i]) begin
                    irq_status[i] <= 1'b0;
                end
            end
        end
    end

    // Mask defaults to all events passing so the enable bit alone suffices
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_mask <= '1;
        end else if (wr && addr == ADDR_IRQ_MASK) begin
            irq_mask <= wdata[EV_W-1:0];
        end
    end

    // Level request while enabled and an unmasked flag is up with its status bit set
    assign irq = rf_irq_enable && |(irq_status & irq_mask & events);

    // ------------------------------------------------------------------
    // Read path, data one cycle after the strobe
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata <= BYTE_ZERO;
        end else if (rd) begin
            case (addr)
                ADDR_STATUS_CTRL: rdata <= {tx_done_flag, tx_error_flag, rf_lowvolt_flag,
                                            1'b0, rf_irq_enable, rf_lowvolt_enable,
                                            ready_to_transmit, 1'b0};
                ADDR_ZERO_HIGH:   rdata <= page0 ? fsk_zero_fraction[FRAC_W-1:FRAC_LO_W]
                                                 : BYTE_ZERO;
                ADDR_ZERO_LOW:    rdata <= page0 ? {fsk_zero_fraction[FRAC_LO_W-1:0],
                                                    data_polarity, coding} : BYTE_ZERO;
                ADDR_PAGE:        rdata <= {7'h00, register_page_select};
                ADDR_IRQ_STATUS:  rdata <= {5'h00, irq_status};
                ADDR_IRQ_MASK:    rdata <= {5'h00, irq_mask};
                default:          rdata <= BYTE_ZERO;
            endcase
        end else begin
            rdata <= BYTE_ZERO;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_done_on_event: assert property (@(posedge mclk) disable iff (rst)
        radio_event.tx_done && !tx_busy && buffer_mode && !unit_rst |=> tx_done_flag)
        else $error("done flag not set by event");
    a_ack_clears: assert property (@(posedge mclk) disable iff (rst)
        flag_clear && !radio_event.tx_error && !unit_rst |=> !tx_error_flag)
        else $error("acknowledge did not clear error flag");
    a_error_sticky: assert property (@(posedge mclk) disable iff (rst)
        tx_error_flag && !flag_clear && !unit_rst |=> tx_error_flag)
        else $error("error flag dropped without clear");
    a_lowv_gated: assert property (@(posedge mclk) disable iff (rst)
        !rf_lowvolt_flag && !rf_lowvolt_enable |=> !rf_lowvolt_flag)
        else $error("low voltage flag set while disabled");
    a_irq_level: assert property (@(posedge mclk) disable iff (rst)
        irq |-> rf_irq_enable && (tx_done_flag || tx_error_flag || rf_lowvolt_flag))
        else $error("interrupt without enabled flag");
    // Reset-bit write, then a lone one; a repeated write stretches the pulse
    sequence s_reset_write;
        wr_ctrl && wdata[BIT_RESET];
    endsequence
    sequence s_lone_reset;
        s_reset_write ##1 !wr_ctrl;
    endsequence
    a_unit_reset_pulse: assert property (@(posedge mclk) disable iff (rst)
        s_reset_write |=> radio_unit_reset)
        else $error("reset pulse missing");
    a_unit_reset_ends: assert property (@(posedge mclk) disable iff (rst)
        s_lone_reset |=> !radio_unit_reset)
        else $error("reset pulse too long");
    a_reset_clears_cfg: assert property (@(posedge mclk) disable iff (rst)
        unit_rst |=> coding == CODE_MANCHESTER && fsk_zero_fraction == FRAC_RESET
                     && !rf_irq_enable)
        else $error("module reset left configuration");
    a_page_blocks: assert property (@(posedge mclk) disable iff (rst)
        register_page_select && !unit_rst |=> $stable(fsk_zero_fraction))
        else $error("divider written on page one");
    a_ready_follows: assert property (@(posedge mclk) disable iff (rst)
        !radio_event.pll_locked |=> !ready_to_transmit)
        else $error("ready without lock");

    // Flag behaviour
    a_done_busy_low: assert property (@(posedge mclk) disable iff (rst)
        tx_busy |=> !tx_done_flag)
        else $error("done flag high while busy");
    a_done_direct_low: assert property (@(posedge mclk) disable iff (rst)
        !buffer_mode |=> !tx_done_flag)
        else $error("done flag high outside buffer mode");
    a_done_last_frame: assert property (@(posedge mclk) disable iff (rst)
        !frame_irq_delay && radio_event.tx_done && !tx_busy && buffer_mode && !unit_rst
        |=> tx_done_flag)
        else $error("done flag missed after last frame");
    a_flags_unit_reset: assert property (@(posedge mclk) disable iff (rst)
        unit_rst |=> !tx_done_flag && !tx_error_flag && !rf_lowvolt_flag)
        else $error("module reset left a flag");
    a_ack_clears_done: assert property (@(posedge mclk) disable iff (rst)
        flag_clear && !radio_event.tx_done |=> !tx_done_flag)
        else $error("acknowledge did not clear done flag");
    a_ack_clears_lowv: assert property (@(posedge mclk) disable iff (rst)
        flag_clear && !radio_event.lowvolt_trip |=> !rf_lowvolt_flag)
        else $error("acknowledge did not clear low voltage flag");
    a_lowv_sets: assert property (@(posedge mclk) disable iff (rst)
        radio_event.lowvolt_trip && rf_lowvolt_enable && !unit_rst |=> rf_lowvolt_flag)
        else $error("low voltage trip lost");
    a_lowv_sticky: assert property (@(posedge mclk) disable iff (rst)
        rf_lowvolt_flag && !flag_clear && !unit_rst |=> rf_lowvolt_flag)
        else $error("low voltage flag dropped without clear");

    // Bus and configuration
    a_reset_reads_zero: assert property (@(posedge mclk) disable iff (rst)
        rd && addr == ADDR_STATUS_CTRL |=> !rdata[BIT_RESET])
        else $error("reset bit read back as one");
    a_page_reads_zero: assert property (@(posedge mclk) disable iff (rst)
        rd && register_page_select && addr == ADDR_ZERO_HIGH |=> rdata == BYTE_ZERO)
        else $error("divider visible on page one");
    a_coding_field: assert property (@(posedge mclk) disable iff (rst)
        wr && page0 && addr == ADDR_ZERO_LOW && !unit_rst |=> coding == $past(wdata[1:0]))
        else $error("coding field not written");
    a_direct_data: assert property (@(posedge mclk) disable iff (rst)
        coding == CODE_MCU_DIRECT |=> radio_data_out == $past(mcu_data_bit ^ data_polarity))
        else $error("direct data output wrong");

endmodule : rf_tx_status_and_encoding_ctrl

// ==== dv/rf_tx_engine_model.sv ====
// Transmit engine and analog front model that feeds radio events to the block
module rf_tx_engine_model
    import rf_tx_pkg::*;
(
    input  wire logic      mclk,
    output radio_event_type radio_event,
    output logic            tx_busy
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------
    // Idle state
    // ------------------------------------------------------------------
    initial begin
        radio_event = '0;
        tx_busy     = 1'b0;
    end

    // One buffer-mode frame: busy for a while, then a one-cycle outcome
    task automatic run_frame(input logic fail);
        @(posedge mclk);
        tx_busy <= 1'b1;
        repeat (4) @(posedge mclk);
        tx_busy              <= 1'b0;
        radio_event.tx_done  <= ~fail;
        radio_event.tx_error <= fail;
        @(posedge mclk);
        radio_event.tx_done  <= 1'b0;
        radio_event.tx_error <= 1'b0;
    endtask : run_frame

    // Supply dip: the detector reports a single-cycle trip
    task automatic trip();
        @(posedge mclk);
        radio_event.lowvolt_trip <= 1'b1;
        @(posedge mclk);
        radio_event.lowvolt_trip <= 1'b0;
    endtask : trip

    // Oscillator and PLL lock is a level; dropping it models a power-down
    task automatic set_lock(input logic v);
        @(posedge mclk);
        radio_event.pll_locked <= v;
    endtask : set_lock

endmodule : rf_tx_engine_model

// ==== dv/rf_tx_status_and_encoding_ctrl_test.sv ====
// Register-level testbench of the RF transmit status and coding block
module rf_tx_status_and_encoding_ctrl_test;
    import rf_tx_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic            mclk = 1'b0;
    logic            rst = 1'b1;
    logic [3:0]      addr = 4'h0;
    logic [7:0]      wdata = 8'h00;
    logic            wr = 1'b0;
    logic            rd = 1'b0;
    logic [7:0]      rdata;
    radio_event_type radio_event;
    logic            carrier_band_select = 1'b0;
    logic            frame_irq_delay = 1'b0;
    logic            tx_busy;
    logic            mcu_data_bit = 1'b1;
    coding_cfg_type  coding_cfg;
    logic            radio_data_out;
    logic            radio_unit_reset;
    logic            rf_lowvolt_enable;
    logic            irq;
    int              bad_count = 0;
    int              checked = 0;

    // 100 MHz clock
    always #5 mclk = ~mclk;

    rf_tx_engine_model i_engine (.mclk(mclk), .radio_event(radio_event), .tx_busy(tx_busy));

    // Frame delay low: the engine already reports the last frame only
    rf_tx_status_and_encoding_ctrl i_dut (
        .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .radio_event(radio_event),
        .carrier_band_select(carrier_band_select), .frame_irq_delay(frame_irq_delay),
        .tx_busy(tx_busy), .mcu_data_bit(mcu_data_bit), .coding_cfg(coding_cfg),
        .radio_data_out(radio_data_out), .radio_unit_reset(radio_unit_reset),
        .rf_lowvolt_enable(rf_lowvolt_enable), .irq(irq)
    );

    // ------------------------------------------------------------------
    // Bus and comparison tasks
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [22:0] seen, input logic [22:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Returns just after the edge that takes the write, so effects are visible
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
        #1;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe, so sample there
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        #1;
        check("rdata", rdata, exp);
    endtask : rd_chk

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    // Watchdog at 10000 cycles, well beyond the under two hundred cycles the sequence needs
    initial begin
        #100000;
        bad_count++;
        wrap_up();
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rd_chk(ADDR_STATUS_CTRL, 8'h00);
        rd_chk(ADDR_ZERO_HIGH, 8'h00);
        rd_chk(ADDR_ZERO_LOW, 8'h00);
        rd_chk(ADDR_IRQ_MASK, 8'h07);
        check("irq", irq, 1'b0);
        check("ratio", coding_cfg.ratio_integer, 5'h0C);
        carrier_band_select <= 1'b1;
        #10 check("ratio", coding_cfg.ratio_integer, 5'h10);
        // Every coding and polarity; only direct mode drives the data output
        wr_reg(ADDR_ZERO_HIGH, 8'hA5);
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 4; c++) begin
                wr_reg(ADDR_ZERO_LOW, {5'h1B, p[0], c[1:0]});
                check("coding", coding_cfg.coding, c[1:0]);
                check("polarity", coding_cfg.data_polarity, p[0]);
                @(posedge mclk);
                #1 check("data_out", radio_data_out, (c == 3) ? p[0] ^ 1'b1 : 1'b0);
            end
        end
        @(posedge mclk);
        mcu_data_bit <= 1'b0;
        @(posedge mclk);
        #1 check("data_out", radio_data_out, 1'b1);
        check("fraction", coding_cfg.fsk_zero_fraction, 13'h14BB);
        rd_chk(ADDR_ZERO_HIGH, 8'hA5);
        rd_chk(ADDR_ZERO_LOW, 8'hDF);
        // Page one hides the divider pair
        wr_reg(ADDR_PAGE, 8'h01);
        rd_chk(ADDR_PAGE, 8'h01);
        rd_chk(ADDR_ZERO_HIGH, 8'h00);
        wr_reg(ADDR_ZERO_HIGH, 8'h11);
        wr_reg(ADDR_ZERO_LOW, 8'h00);
        wr_reg(ADDR_PAGE, 8'h00);
        rd_chk(ADDR_ZERO_HIGH, 8'hA5);
        rd_chk(ADDR_ZERO_LOW, 8'hDF);
        rd_chk(4'hF, 8'h00);
        // Flag bits and ready bit ignore writes
        wr_reg(ADDR_STATUS_CTRL, 8'hEE);
        check("lv_enable", rf_lowvolt_enable, 1'b1);
        rd_chk(ADDR_STATUS_CTRL, 8'h0C);
        i_engine.trip();
        rd_chk(ADDR_STATUS_CTRL, 8'h2C);
        check("irq", irq, 1'b1);
        wr_reg(ADDR_IRQ_MASK, 8'h00);
        check("irq", irq, 1'b0);
        wr_reg(ADDR_IRQ_MASK, 8'h07);
        check("irq", irq, 1'b1);
        wr_reg(ADDR_STATUS_CTRL, 8'h1C);
        rd_chk(ADDR_STATUS_CTRL, 8'h0C);
        check("irq", irq, 1'b0);
        rd_chk(ADDR_IRQ_STATUS, 8'h04);
        wr_reg(ADDR_IRQ_STATUS, 8'h04);
        rd_chk(ADDR_IRQ_STATUS, 8'h00);
        // Detector disabled: a trip leaves no trace
        wr_reg(ADDR_STATUS_CTRL, 8'h08);
        i_engine.trip();
        rd_chk(ADDR_STATUS_CTRL, 8'h08);
        // Direct mode is not buffer mode: a clean frame leaves done low
        i_engine.run_frame(1'b0);
        rd_chk(ADDR_STATUS_CTRL, 8'h08);
        wr_reg(ADDR_ZERO_LOW, 8'hD8);
        // Frames: done only after a clean finish, error is sticky
        i_engine.run_frame(1'b0);
        rd_chk(ADDR_STATUS_CTRL, 8'h88);
        check("irq", irq, 1'b1);
        wr_reg(ADDR_STATUS_CTRL, 8'h08);
        rd_chk(ADDR_STATUS_CTRL, 8'h88);
        fork
            i_engine.run_frame(1'b1);
            begin
                repeat (2) @(posedge mclk);
                rd_chk(ADDR_STATUS_CTRL, 8'h08);
            end
        join
        rd_chk(ADDR_STATUS_CTRL, 8'h48);
        i_engine.run_frame(1'b0);
        rd_chk(ADDR_STATUS_CTRL, 8'hC8);
        i_engine.set_lock(1'b1);
        rd_chk(ADDR_STATUS_CTRL, 8'hCA);
        i_engine.set_lock(1'b0);
        rd_chk(ADDR_STATUS_CTRL, 8'hC8);
        // Radio reset clears the unit but keeps page select and mask
        wr_reg(ADDR_IRQ_MASK, 8'h03);
        wr_reg(ADDR_PAGE, 8'h01);
        wr_reg(ADDR_STATUS_CTRL, 8'h0D);
        check("unit_reset", radio_unit_reset, 1'b1);
        @(posedge mclk);
        #1 check("unit_reset", radio_unit_reset, 1'b0);
        rd_chk(ADDR_STATUS_CTRL, 8'h00);
        check("irq", irq, 1'b0);
        check("lv_enable", rf_lowvolt_enable, 1'b0);
        check("fraction", coding_cfg.fsk_zero_fraction, 13'h0000);
        check("polarity", coding_cfg.data_polarity, 1'b0);
        check("coding", coding_cfg.coding, CODE_MANCHESTER);
        rd_chk(ADDR_PAGE, 8'h01);
        rd_chk(ADDR_IRQ_MASK, 8'h03);
        rd_chk(ADDR_IRQ_STATUS, 8'h00);
        wr_reg(ADDR_PAGE, 8'h00);
        rd_chk(ADDR_ZERO_HIGH, 8'h00);
        rd_chk(ADDR_ZERO_LOW, 8'h00);
        wrap_up();
    end

endmodule : rf_tx_status_and_encoding_ctrl_test
